// ### shared/supervisor_pkg.sv
package supervisor_pkg;

  // ------------------------------------------------------------
  // timing, in seconds
  // ------------------------------------------------------------
  localparam real CLK_HZ            = 25.0e6;
  localparam real HOLD_TIME_S       = 1.12e-3;  // reset_hold_time, plain default
  localparam real WD_LONG_S         = 35.0;
  localparam real WD_SHORT_S        = 1.12;
  localparam int  HOLD_CYCLES       = int'($ceil(HOLD_TIME_S * CLK_HZ));
  localparam int  WD_LONG_CYCLES    = int'($ceil(WD_LONG_S * CLK_HZ));
  localparam int  WD_SHORT_CYCLES   = int'($ceil(WD_SHORT_S * CLK_HZ));
  localparam int  CNT_W             = 32;

  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic RST_N_INIT = 1'b0;
  localparam logic RST_H_INIT = 1'b1;
  localparam logic WARN_N_INIT = 1'b1;
  // synchroniser reset image: only the manual reset bit idles high
  localparam logic [31:0] SYNC_INIT = 32'h0000_0008;

  typedef enum logic [1:0] {
    MODE_LONG  = 2'b00,
    MODE_SHORT = 2'b01
  } wd_mode_t;

endpackage

// ### shared/sync_bus_if.sv
`timescale 1ns/1ns
interface sync_bus_if #(parameter int N = 6);
  logic [N-1:0] raw;
  logic [N-1:0] synced;
  modport src (output raw, input synced);
  modport dst (input raw, output synced);
endinterface

// ### rtl/sync_stage.sv
`timescale 1ns/1ns
module sync_stage #(
  parameter int          N     = 6,
  parameter logic [31:0] INIT  = 32'h0000_0000
) (
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic rst,
  // bits
  sync_bus_if.dst   bus
);
  logic [N-1:0] meta_r;
  logic [N-1:0] sync_r;

  if (N < 1 || N > 32) begin : g_bad_width
    $error("sync_stage: N out of range");
  end

  // two flops per bit; meta_r feeds only sync_r
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      meta_r <= INIT[N-1:0];
      sync_r <= INIT[N-1:0];
    end else begin
      meta_r <= bus.raw;
      sync_r <= meta_r;
    end
  end

  assign bus.synced = sync_r;
endmodule

// ### rtl/supply_supervisor_watchdog.sv
`timescale 1ns/1ns
// What this block does
// - any supply undervoltage, aux undervoltage or low manual reset asserts every reset output.
// - the active-low reset stays low a full hold period after all causes clear.
// - an undervoltage that returns during the hold period restarts the hold count from zero.
// - reset is held while manual reset is low and for the hold period after it rises.
// - every reset event puts the watchdog into its long initial mode of at least 35 s.
// - the first toggle edge in the long mode outside reset switches to the short mode of at least 1.12 s.
// - in short mode, no toggle edge within the timeout issues a reset pulse of hold length.
// - the power warning output goes low while the comparator reports below reference.
// - the power warning output returns high at once when the comparator clears, unstretched.
// - the active-high reset follows every cause of the active-low one, for the same time.
// - both active-low reset outputs come from one internal reset state.
// - the watchdog counter clears while reset is asserted and on every toggle edge.
module supply_supervisor_watchdog
  import supervisor_pkg::*;
#(
  parameter int HOLD_CNT   = HOLD_CYCLES,
  parameter int WD_LONG    = WD_LONG_CYCLES,
  parameter int WD_SHORT   = WD_SHORT_CYCLES
) (
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic rst,
  // supply monitors, high = below threshold
  input  wire logic primary_undervolt,
  input  wire logic secondary_undervolt,
  input  wire logic aux_undervolt_in,
  // host side
  input  wire logic manual_reset_in_n,
  input  wire logic watchdog_toggle_in,
  // power-fail comparator, high = input below reference
  input  wire logic power_warn_sense,
  // outputs
  output logic      first_reset_out_n,
  output logic      second_reset_out_n,
  output logic      reset_out,
  output logic      power_warn_out_n
);

  // the hold checks below need at least two hold cycles
  if (HOLD_CNT < 2 || WD_SHORT < 1 || WD_LONG < WD_SHORT) begin : g_bad_timing
    $error("supply_supervisor_watchdog: bad timing parameters");
  end

  // ------------------------------------------------------------
  // input synchronisers
  // ------------------------------------------------------------
  sync_bus_if #(.N(6)) sbus ();

  assign sbus.raw = {power_warn_sense, watchdog_toggle_in, manual_reset_in_n,
                     aux_undervolt_in, secondary_undervolt, primary_undervolt};

  // init: manual reset released, others idle
  sync_stage #(
    .N    (6),
    .INIT (SYNC_INIT)
  ) u_sync (
    .clk_sys (clk_sys),
    .rst     (rst),
    .bus     (sbus.dst)
  );

  logic uv_s;
  logic mr_n_s;
  logic wdi_s;
  logic pf_s;
  assign uv_s   = |sbus.synced[2:0];
  assign mr_n_s = sbus.synced[3];
  assign wdi_s  = sbus.synced[4];
  assign pf_s   = sbus.synced[5];

  // ------------------------------------------------------------
  // reset state
  // ------------------------------------------------------------
  logic             cause;
  logic             wd_fire;
  logic [CNT_W-1:0] hold_r;
  logic             in_rst_r;

  assign cause = uv_s | ~mr_n_s;

  // hold count restarts from zero while any cause is present
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      hold_r   <= '0;
      in_rst_r <= 1'b1;
    end else if (cause || wd_fire) begin
      hold_r   <= '0;
      in_rst_r <= 1'b1;
    end else if (in_rst_r) begin
      if (hold_r >= CNT_W'(HOLD_CNT - 1)) begin
        in_rst_r <= 1'b0;
      end else begin
        hold_r <= hold_r + 1'b1;
      end
    end
  end

  // one common state drives all reset pins
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      first_reset_out_n  <= RST_N_INIT;
      second_reset_out_n <= RST_N_INIT;
      reset_out          <= RST_H_INIT;
    end else begin
      first_reset_out_n  <= ~(in_rst_r | cause);
      second_reset_out_n <= ~(in_rst_r | cause);
      reset_out          <= in_rst_r | cause;
    end
  end

  // ------------------------------------------------------------
  // watchdog
  // ------------------------------------------------------------
  wd_mode_t         mode_r;
  logic [CNT_W-1:0] wd_r;
  logic             wdi_d_r;
  logic             edge_seen;
  logic [CNT_W-1:0] wd_limit;

  assign edge_seen = wdi_s ^ wdi_d_r;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wdi_d_r <= 1'b0;
    end else begin
      wdi_d_r <= wdi_s;
    end
  end

  // a timeout fires once; the reset it raises then clears the counter
  // an edge in the deadline cycle still counts as in time, so it wins over the timeout
  assign wd_limit = (mode_r == MODE_LONG) ? CNT_W'(WD_LONG - 1) : CNT_W'(WD_SHORT - 1);
  assign wd_fire  = ~in_rst_r && ~edge_seen && (wd_r >= wd_limit);

  always_ff @(posedge clk_sys) begin
    if (rst || in_rst_r || cause) begin
      wd_r   <= '0;
      mode_r <= MODE_LONG;
    end else if (edge_seen) begin
      wd_r   <= '0;
      mode_r <= MODE_SHORT;
    end else begin
      wd_r <= wd_r + 1'b1;
    end
  end

  // ------------------------------------------------------------
  // power warning, no stretching
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      power_warn_out_n <= WARN_N_INIT;
    end else begin
      power_warn_out_n <= ~pf_s;
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  logic [CNT_W-1:0] since_r;
  logic [CNT_W-1:0] idle_wd_r;
  logic             kicked_r;

  // cycles since the last reset event, saturating at the hold length
  always_ff @(posedge clk_sys) begin
    if (rst || cause || wd_fire) begin
      since_r <= '0;
    end else if (since_r < CNT_W'(HOLD_CNT)) begin
      since_r <= since_r + 1'b1;
    end
  end

  // cycles since the last toggle edge or reset; saturates so it cannot wrap
  always_ff @(posedge clk_sys) begin
    if (rst || in_rst_r || cause || edge_seen) begin
      idle_wd_r <= '0;
    end else if (idle_wd_r < CNT_W'(WD_LONG)) begin
      idle_wd_r <= idle_wd_r + 1'b1;
    end
  end

  // set by the first toggle edge seen outside reset
  always_ff @(posedge clk_sys) begin
    if (rst || in_rst_r || cause) begin
      kicked_r <= 1'b0;
    end else if (edge_seen) begin
      kicked_r <= 1'b1;
    end
  end

  sequence cause_gone_s;
    !cause ##1 !cause;
  endsequence

  sequence fire_then_reset_s;
    wd_fire ##1 in_rst_r;
  endsequence

  cause_resets_a: assert property (@(posedge clk_sys) disable iff (rst)
    cause |=> !first_reset_out_n && reset_out)
    else $error("reset not asserted on cause");

  aux_cause_a: assert property (@(posedge clk_sys) disable iff (rst)
    sbus.synced[2] |=> reset_out)
    else $error("aux undervoltage gave no reset");

  hold_after_a: assert property (@(posedge clk_sys) disable iff (rst)
    $fell(cause) |=> !first_reset_out_n [*2])
    else $error("reset released too early");

  hold_full_a: assert property (@(posedge clk_sys) disable iff (rst)
    since_r < CNT_W'(HOLD_CNT) |=> !first_reset_out_n)
    else $error("reset released before the hold period");

  hold_release_a: assert property (@(posedge clk_sys) disable iff (rst)
    (since_r == CNT_W'(HOLD_CNT) && !cause && !wd_fire) |=> first_reset_out_n && !reset_out)
    else $error("reset held past the hold period");

  hold_restart_a: assert property (@(posedge clk_sys) disable iff (rst)
    cause |=> hold_r == '0)
    else $error("hold count not restarted");

  manual_hold_a: assert property (@(posedge clk_sys) disable iff (rst)
    !mr_n_s |=> !second_reset_out_n)
    else $error("manual reset ignored");

  manual_release_a: assert property (@(posedge clk_sys) disable iff (rst)
    $rose(mr_n_s) |=> !first_reset_out_n)
    else $error("manual reset not stretched");

  long_mode_a: assert property (@(posedge clk_sys) disable iff (rst)
    in_rst_r |=> mode_r == MODE_LONG)
    else $error("watchdog not in long mode after reset");

  edge_ignored_a: assert property (@(posedge clk_sys) disable iff (rst)
    (edge_seen && in_rst_r) |=> mode_r == MODE_LONG)
    else $error("toggle during reset left long mode");

  wd_long_wait_a: assert property (@(posedge clk_sys) disable iff (rst)
    (wd_fire && !kicked_r) |-> idle_wd_r >= CNT_W'(WD_LONG - 1))
    else $error("long mode timed out early");

  mode_after_fire_a: assert property (@(posedge clk_sys) disable iff (rst)
    fire_then_reset_s |=> mode_r == MODE_LONG && wd_r == '0)
    else $error("watchdog reset did not restore long mode");

  short_mode_a: assert property (@(posedge clk_sys) disable iff (rst)
    (edge_seen && !in_rst_r && !cause) |=> mode_r == MODE_SHORT && wd_r == '0)
    else $error("toggle did not enter normal mode");

  mode_stays_a: assert property (@(posedge clk_sys) disable iff (rst)
    (mode_r == MODE_SHORT && !in_rst_r && !cause) |=> mode_r == MODE_SHORT)
    else $error("normal mode left without reset");

  wd_short_wait_a: assert property (@(posedge clk_sys) disable iff (rst)
    wd_fire |-> idle_wd_r >= CNT_W'(WD_SHORT - 1))
    else $error("watchdog fired before the short timeout");

  wd_fire_a: assert property (@(posedge clk_sys) disable iff (rst)
    wd_fire |=> in_rst_r ##1 !first_reset_out_n)
    else $error("watchdog timeout gave no reset");

  wd_short_fire_a: assert property (@(posedge clk_sys) disable iff (rst)
    (kicked_r && !in_rst_r && !cause && !edge_seen &&
     idle_wd_r >= CNT_W'(WD_SHORT - 1)) |-> wd_fire)
    else $error("short timeout passed without reset");

  warn_follow_a: assert property (@(posedge clk_sys) disable iff (rst)
    ##1 power_warn_out_n == !$past(pf_s))
    else $error("power warning does not follow comparator");

  warn_assert_a: assert property (@(posedge clk_sys) disable iff (rst)
    $rose(pf_s) |=> !power_warn_out_n)
    else $error("power warning not raised");

  warn_release_a: assert property (@(posedge clk_sys) disable iff (rst)
    $fell(pf_s) |=> power_warn_out_n)
    else $error("power warning stretched");

  warn_idle_a: assert property (@(posedge clk_sys) disable iff (rst)
    !pf_s |=> power_warn_out_n)
    else $error("power warning low without cause");

  polarity_pair_a: assert property (@(posedge clk_sys) disable iff (rst)
    reset_out == !first_reset_out_n && first_reset_out_n == second_reset_out_n)
    else $error("reset outputs disagree");

  reset_state_a: assert property (@(posedge clk_sys)
    rst |=> !first_reset_out_n && !second_reset_out_n && reset_out && power_warn_out_n)
    else $error("outputs wrong during reset");

  wd_clear_a: assert property (@(posedge clk_sys) disable iff (rst)
    cause_gone_s |-> ##0 (in_rst_r || wd_r <= CNT_W'(WD_LONG)))
    else $error("watchdog count out of range");

  wd_clear_rst_a: assert property (@(posedge clk_sys) disable iff (rst)
    in_rst_r |=> wd_r == '0)
    else $error("watchdog count not cleared in reset");

  edge_clear_a: assert property (@(posedge clk_sys) disable iff (rst)
    edge_seen |=> wd_r == '0)
    else $error("watchdog count not cleared on toggle");

endmodule

// ### sim/host_model.sv
`timescale 1ns/1ns
module host_model #(
  parameter int PERIOD = 20
) (
  // clock
  input  wire logic clk_sys,
  // bench control
  input  wire logic kick_en,
  // toward the supervisor
  output logic      watchdog_toggle_in
);
  int cnt_r = 0;
  initial watchdog_toggle_in = 1'b0;
  // stopping the kicks leaves the level stuck, which is the fault under test
  always @(posedge clk_sys) begin
    if (kick_en && cnt_r == PERIOD - 1) begin
      watchdog_toggle_in <= ~watchdog_toggle_in;
      cnt_r              <= 0;
    end else if (kick_en) begin
      cnt_r <= cnt_r + 1;
    end
  end
endmodule

// ### sim/tb.sv
`timescale 1ns/1ns
module tb;
  import supervisor_pkg::*;
  localparam int HOLD = 8;
  localparam int WDL  = 200;
  localparam int WDS  = 50;
  logic clk_sys             = 1'b0;
  logic rst                 = 1'b1;
  logic primary_undervolt   = 1'b0;
  logic secondary_undervolt = 1'b0;
  logic aux_undervolt_in    = 1'b0;
  logic manual_reset_in_n   = 1'b1;
  logic power_warn_sense    = 1'b0;
  logic kick_en             = 1'b1;
  logic watchdog_toggle_in, first_reset_out_n, second_reset_out_n, reset_out, power_warn_out_n;
  int   err_total           = 0;
  int   n_tests             = 0;
  int   n;
  logic seen;

  initial forever #20 clk_sys = ~clk_sys;

  host_model #(.PERIOD(20)) i_host_model (
    .clk_sys(clk_sys), .kick_en(kick_en), .watchdog_toggle_in(watchdog_toggle_in));

  supply_supervisor_watchdog #(.HOLD_CNT(HOLD), .WD_LONG(WDL), .WD_SHORT(WDS))
    i_supply_supervisor_watchdog (
    .clk_sys(clk_sys), .rst(rst), .primary_undervolt(primary_undervolt),
    .secondary_undervolt(secondary_undervolt), .aux_undervolt_in(aux_undervolt_in),
    .manual_reset_in_n(manual_reset_in_n), .watchdog_toggle_in(watchdog_toggle_in),
    .power_warn_sense(power_warn_sense), .first_reset_out_n(first_reset_out_n),
    .second_reset_out_n(second_reset_out_n), .reset_out(reset_out),
    .power_warn_out_n(power_warn_out_n));

  // ----------------------------------------------------------
  // helpers
  // ----------------------------------------------------------
  task end_sim;
    if (err_total == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task tick(input int k);
    repeat (k) @(posedge clk_sys);
    #1;
  endtask

  task chk(input string what, input logic exp, input logic got);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value %s exp %b got %b", what, exp, got);
    end
  endtask

  task outs(input logic a);
    chk("first_reset_out_n", ~a, first_reset_out_n);
    chk("second_reset_out_n", ~a, second_reset_out_n);
    chk("reset_out", a, reset_out);
  endtask

  // bounded wait for reset_out to reach a level; cycles spent returned in n
  task wait_rst(input logic a, input int bound);
    n = 0;
    while (reset_out !== a) begin
      if (n == bound) begin
        err_total++;
        $display("wrong value reset_out exp %b got %b", a, reset_out);
        end_sim();
      end
      tick(1);
      n++;
    end
  endtask

  task set_cause(input int k, input logic v);
    @(posedge clk_sys);
    case (k)
      0: primary_undervolt <= v;
      1: secondary_undervolt <= v;
      2: aux_undervolt_in <= v;
      default: manual_reset_in_n <= ~v;
    endcase
  endtask

  // ----------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------
  task t_power_up;
    tick(1);
    outs(1);
    wait_rst(0, HOLD + 8);
    chk("hold after release", 1'b1, n >= HOLD);
    outs(0);
  endtask

  task t_causes;
    for (int k = 0; k < 4; k++) begin
      set_cause(k, 1'b1);
      wait_rst(1, 5);
      outs(1);
      tick(3);
      set_cause(k, 1'b0);
      tick(HOLD);
      outs(1);
      wait_rst(0, 10);
    end
  endtask

  task t_restart;
    set_cause(0, 1'b1);
    tick(5);
    set_cause(0, 1'b0);
    tick(4);
    set_cause(2, 1'b1);
    tick(3);
    set_cause(2, 1'b0);
    tick(HOLD);
    outs(1);
    wait_rst(0, 10);
  endtask

  task t_warn;
    @(posedge clk_sys) power_warn_sense <= 1'b1;
    tick(4);
    chk("power_warn_out_n", 1'b0, power_warn_out_n);
    outs(0);
    @(posedge clk_sys) power_warn_sense <= 1'b0;
    tick(4);
    chk("power_warn_out_n", 1'b1, power_warn_out_n);
  endtask

  task t_watchdog;
    seen = 1'b0;
    repeat (WDL + 100) begin
      tick(1);
      seen = seen | reset_out;
    end
    chk("reset_out while kicked", 1'b0, seen);
    @(posedge clk_sys) kick_en <= 1'b0;
    wait_rst(1, WDS + 10);
    wait_rst(0, HOLD + 4);
    chk("watchdog pulse length", 1'b1, n >= HOLD);
    seen = 1'b0;
    repeat (WDS + 20) begin
      tick(1);
      seen = seen | reset_out;
    end
    chk("reset_out in long mode", 1'b0, seen);
    wait_rst(1, WDL);
    @(posedge clk_sys) kick_en <= 1'b1;
    wait_rst(0, HOLD + 6);
  endtask

  initial begin
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    t_power_up();
    t_causes();
    t_restart();
    t_warn();
    t_watchdog();
    end_sim();
  end
endmodule
